// ==== hw/line_alarm_pkg.sv ====
// constants, types and helpers shared by the alarm and loopback block
package line_alarm_pkg;
  localparam int CHANNELS = 4;                // line channels per device
  localparam int CNT_W = 8;                   // width of bit-position counters
  localparam logic [7:0] DS1_ZERO_LIMIT = 8'h64;   // 100 zeros
  localparam logic [7:0] CEPT_ZERO_LIMIT = 8'hFF;  // 255 zeros
  localparam int DENSITY_SHIFT = 3;           // 12.5% is one eighth
  localparam logic [7:0] TX_IDLE_LIMIT = 8'h20;    // zero bits meaning no data sent
  localparam int CLK_PERIOD_PS = 25000;       // ref_clk period, 40 MHz
  localparam int CLK_LOSS_NS = 2000;          // silence that counts as a lost clock
  // least time: round up to whole cycles
  localparam int CLK_LOSS_CYCLES = (CLK_LOSS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WATCH_N = 17;                // watched clock signals
  // reset values of the alarm outputs (inactive)
  localparam logic ALARM_N_RESET = 1'b1;
  localparam logic REF_LOSS_RESET = 1'b0;

  // loopback selection per channel
  typedef enum logic [1:0] {
    LOOP_NONE = 2'b00,
    LOOP_FULL_LOCAL = 2'b01,
    LOOP_REMOTE = 2'b10,
    LOOP_DIGITAL = 2'b11
  } loop_mode_e;

  // one active-low request selects a loop; none or several select nothing
  function automatic loop_mode_e loop_decode(input logic fl_n, input logic rl_n,
                                             input logic dl_n);
    case ({fl_n, rl_n, dl_n})
      3'b011: loop_decode = LOOP_FULL_LOCAL;
      3'b101: loop_decode = LOOP_REMOTE;
      3'b110: loop_decode = LOOP_DIGITAL;
      default: loop_decode = LOOP_NONE;
    endcase
  endfunction : loop_decode

  // length of the zero run and of the density window
  function automatic logic [7:0] zero_limit(input logic cept);
    zero_limit = cept ? CEPT_ZERO_LIMIT : DS1_ZERO_LIMIT;
  endfunction : zero_limit

  // saturating increment of a bit-position count
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction : sat_inc
endpackage : line_alarm_pkg

// ==== hw/clk_watch_if.sv ====
// carrier between the alarm block and its clock activity watcher
`timescale 1ns/1ps
interface clk_watch_if #(parameter int N = 17);
  logic [N-1:0] sample;  // sampled clock levels
  logic [N-1:0] lost;    // level per clock: no edge for the loss time
  modport watcher (input sample, output lost);
  modport user (output sample, input lost);
endinterface : clk_watch_if

// ==== hw/clk_watch.sv ====
// clock activity watcher: flags each clock that stops toggling
`timescale 1ns/1ps
module clk_watch
  import line_alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  clk_watch_if.watcher w
);
  localparam int N = WATCH_N;
  localparam logic [7:0] LIMIT = 8'(CLK_LOSS_CYCLES);

  logic [N-1:0] prev_reg;        // last sampled level per clock
  logic [7:0] quiet_reg [N];     // cycles since the last edge
  logic [N-1:0] lost_reg;        // loss flags

  //////////////////////////////////////////////////////////////////////////////
  // edge memory
  always_ff @(posedge ref_clk) begin
    if (rst) prev_reg <= '0;
    else prev_reg <= w.sample;
  end

  // quiet counters restart on any edge, stop at the limit
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < N; i++) begin
      if (rst) quiet_reg[i] <= 8'h00;
      else if (prev_reg[i] != w.sample[i]) quiet_reg[i] <= 8'h00;
      else if (quiet_reg[i] != LIMIT) quiet_reg[i] <= quiet_reg[i] + 8'h01;
    end
  end

  // loss declared at the limit; a single edge clears it
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < N; i++) begin
      if (rst) lost_reg[i] <= 1'b0;
      else lost_reg[i] <= (quiet_reg[i] == LIMIT) && (prev_reg[i] == w.sample[i]);
    end
  end

  assign w.lost = lost_reg;
endmodule : clk_watch

// ==== hw/line_alarm_loopback_control.sv ====
// per-channel line alarms and loopback selection for a four-channel line interface
`timescale 1ns/1ps

// Operation
// - single rail: violation pulse one bit, polarity selectable
// - dual rail: shared pin carries negative rail
// - analog loss with two-threshold hysteresis
// - DS1: digital loss after 100 zeros
// - CEPT: digital loss after 255 zeros
// - release when ones density exceeds one eighth
// - drive monitor low on fault or idle
// - clock loss low on the channel whose tx clock stops
// - reference loss high while reference absent
// - alarm test forces channel alarms active
// - reference loss forced only if all tested
// - alarm test never touches line data
// - full local loop enables analog turnaround
// - remote loop sends received data out
// - remote loop plus alarm request sends AIS
// - digital local loop feeds tx into rx
// - several loop requests cancel all loops
// - AIS is continuous all ones
// - AIS beats looped data
module line_alarm_loopback_control
  import line_alarm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dual_rail,
  input wire logic alarm_polarity_select,
  input wire logic [3:0] cept_mode,
  input wire logic [3:0] rx_bit_strobe,
  input wire logic [3:0] rx_line_positive,
  input wire logic [3:0] rx_line_negative,
  input wire logic [3:0] rx_below_low,
  input wire logic [3:0] rx_above_high,
  input wire logic [3:0] tx_bit_strobe,
  input wire logic [3:0] tx_data_pos,
  input wire logic [3:0] tx_data_neg,
  input wire logic [3:0] tx_primary_fault,
  input wire logic [3:0] tx_clock_in,
  input wire logic [3:0] ja_clock,
  input wire logic [3:0] pwc_clock,
  input wire logic ja_tx_enable,
  input wire logic reference_clock,
  input wire logic [3:0] alarm_test_n,
  input wire logic [3:0] full_local_loop_n,
  input wire logic [3:0] remote_loop_n,
  input wire logic [3:0] digital_local_loop_n,
  input wire logic [3:0] tx_alarm_indication,
  output logic [3:0] rx_data_out,
  output logic [3:0] rx_data_strobe,
  output logic [3:0] coding_violation_flag,
  output logic [3:0] analog_signal_loss_n,
  output logic [3:0] digital_signal_loss_n,
  output logic [3:0] tx_drive_alarm_n,
  output logic [3:0] tx_clock_loss_n,
  output logic ref_clock_loss,
  output logic [3:0] tx_line_pos,
  output logic [3:0] tx_line_neg,
  output logic [3:0] full_local_active,
  output logic [3:0] remote_active,
  output logic [3:0] digital_local_active
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  loop_mode_e loop_reg [CHANNELS];   // decoded loopback per channel
  logic [3:0] rxs;                   // receive bit strobe after loop mux
  logic [3:0] rxp;                   // receive positive rail after loop mux
  logic [3:0] rxn;                   // receive negative rail after loop mux
  logic [7:0] zeros_reg [CHANNELS];  // consecutive zero count
  logic [7:0] win_reg [CHANNELS];    // position in the density window
  logic [7:0] ones_reg [CHANNELS];   // ones seen in the window
  logic [3:0] digital_signal_loss_n_reg;              // digital loss held, active high
  logic [3:0] last_neg_reg;          // polarity of the previous mark
  logic [3:0] bpv_reg;               // violation seen on the last bit
  logic [3:0] negbit_reg;            // negative rail of the last bit
  logic [3:0] mark_seen_reg; // a single-rail mark arrived since reset
  logic [3:0] analog_signal_loss_n_reg;              // analog loss held, active high
  logic [7:0] txzero_reg [CHANNELS]; // zero bits put on the line
  logic [3:0] ais_phase_reg;         // alternates mark polarity for AIS
  logic [WATCH_N-1:0] lost;          // clock loss flags from the watcher

  clk_watch_if #(.N(WATCH_N)) watch ();

  //////////////////////////////////////////////////////////////////////////////
  // clock watching: tx, recovered, jitter attenuator, pulse width, reference

  assign watch.sample = {reference_clock, pwc_clock, ja_clock, rx_bit_strobe, tx_clock_in};
  assign lost = watch.lost;

  clk_watch u_watch (
    .ref_clk(ref_clk),
    .rst(rst),
    .w(watch)
  );

  //////////////////////////////////////////////////////////////////////////////
  // loopback selection

  // requests are re-decoded every cycle; conflicting requests give no loop
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        loop_reg[i] <= LOOP_NONE;
      end else begin
        loop_reg[i] <= loop_decode(full_local_loop_n[i], remote_loop_n[i],
                                   digital_local_loop_n[i]);
      end
    end
  end

  // loop status outputs; the full local loop turns the analog path around
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        full_local_active[i] <= 1'b0;
        remote_active[i] <= 1'b0;
        digital_local_active[i] <= 1'b0;
      end else begin
        // the decode leaves at most one of these set
        full_local_active[i] <= (loop_reg[i] == LOOP_FULL_LOCAL);
        remote_active[i] <= (loop_reg[i] == LOOP_REMOTE);
        digital_local_active[i] <= (loop_reg[i] == LOOP_DIGITAL);
      end
    end
  end

  // receive input: digital local loop takes the tx rails, bypassing analog
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (loop_reg[i] == LOOP_DIGITAL) begin
        rxs[i] = tx_bit_strobe[i];
        rxp[i] = tx_data_pos[i];
        rxn[i] = tx_data_neg[i];
      end else begin
        rxs[i] = rx_bit_strobe[i];
        rxp[i] = rx_line_positive[i];
        rxn[i] = rx_line_negative[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit line

  // AIS first, then remote loop data, then terminal data; alarm test is
  // deliberately absent here so line data never changes under test
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        tx_line_pos[i] <= 1'b0;
        tx_line_neg[i] <= 1'b0;
        ais_phase_reg[i] <= 1'b0;
      end else if (tx_alarm_indication[i] && tx_bit_strobe[i]) begin
        // all ones as alternating marks
        tx_line_pos[i] <= ~ais_phase_reg[i];
        tx_line_neg[i] <= ais_phase_reg[i];
        ais_phase_reg[i] <= ~ais_phase_reg[i];
      end else if (tx_alarm_indication[i]) begin
        // hold the mark between strobes
        tx_line_pos[i] <= tx_line_pos[i];
      end else if (loop_reg[i] == LOOP_REMOTE) begin
        // the recovered bit goes straight back out
        if (rx_bit_strobe[i]) begin
          tx_line_pos[i] <= rx_line_positive[i];
          tx_line_neg[i] <= rx_line_negative[i];
        end
      end else if (tx_bit_strobe[i]) begin
        // terminal data when nothing overrides it
        tx_line_pos[i] <= tx_data_pos[i];
        tx_line_neg[i] <= tx_data_neg[i];
      end
    end
  end

  // consecutive zeros sent, for the no-data part of the drive monitor
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) txzero_reg[i] <= 8'h00;
      else if (tx_bit_strobe[i] && (tx_line_pos[i] || tx_line_neg[i]))
        txzero_reg[i] <= 8'h00;
      else if (tx_bit_strobe[i]) txzero_reg[i] <= sat_inc(txzero_reg[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive data to the terminal

  // unipolar data: in single rail a mark on either rail is a one; dual rail takes the positive rail
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        rx_data_out[i] <= 1'b0;
        rx_data_strobe[i] <= 1'b0;
      end else begin
        rx_data_strobe[i] <= rxs[i];
        if (rxs[i]) rx_data_out[i] <= dual_rail ? rxp[i] : (rxp[i] | rxn[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bipolar violation detection

  // a violation is a mark with the same polarity as the previous mark, or
  // both rails at once; substitution codes are not excluded here
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        last_neg_reg[i] <= 1'b0;
        mark_seen_reg[i] <= 1'b0;
        bpv_reg[i] <= 1'b0;
        negbit_reg[i] <= 1'b0;
      end else if (rxs[i]) begin
        negbit_reg[i] <= rxn[i];
        // flag stands for exactly one bit period, until the next strobe
        // the first mark after reset has nothing to repeat, so it is clean
        bpv_reg[i] <= (rxp[i] && rxn[i]) ||
                      (mark_seen_reg[i] && rxp[i] && !last_neg_reg[i]) ||
                      (mark_seen_reg[i] && rxn[i] && last_neg_reg[i]);
        if (rxp[i] ^ rxn[i]) begin
          last_neg_reg[i] <= rxn[i];
          mark_seen_reg[i] <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // digital loss of signal

  // zero run per channel, cleared by any one, saturating
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) zeros_reg[i] <= 8'h00;
      else if (rxs[i] && (rxp[i] || rxn[i])) zeros_reg[i] <= 8'h00;
      else if (rxs[i]) zeros_reg[i] <= sat_inc(zeros_reg[i]);
    end
  end

  // declare on a full zero run; while declared, judge density per window
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        digital_signal_loss_n_reg[i] <= 1'b0;
        win_reg[i] <= 8'h00;
        ones_reg[i] <= 8'h00;
      end else if (rxs[i] && !digital_signal_loss_n_reg[i]) begin
        win_reg[i] <= 8'h00;
        ones_reg[i] <= 8'h00;
        // the strobe of the last zero of the run declares
        if (!(rxp[i] || rxn[i]) &&
            ({1'b0, zeros_reg[i]} + 9'h001 >= {1'b0, zero_limit(cept_mode[i])}))
          digital_signal_loss_n_reg[i] <= 1'b1;
      end else if (rxs[i]) begin
        // declared: judge ones density window by window
        if (win_reg[i] + 8'h01 == zero_limit(cept_mode[i])) begin
          // window complete: ones times eight above the length releases
          win_reg[i] <= 8'h00;
          ones_reg[i] <= 8'h00;
          if (({3'b000, ones_reg[i]} + {10'h000, rxp[i] | rxn[i]}) << DENSITY_SHIFT >
              {3'b000, zero_limit(cept_mode[i])})
            digital_signal_loss_n_reg[i] <= 1'b0;
        end else begin
          win_reg[i] <= win_reg[i] + 8'h01;
          ones_reg[i] <= ones_reg[i] + {7'h00, rxp[i] | rxn[i]};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog loss of signal

  // two comparators give hysteresis; between thresholds the state holds
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) analog_signal_loss_n_reg[i] <= 1'b0;
      // below the low threshold outranks above the high
      else if (rx_below_low[i]) analog_signal_loss_n_reg[i] <= 1'b1;
      else if (rx_above_high[i]) analog_signal_loss_n_reg[i] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // alarm outputs, with alarm test override applied last

  // receive alarms
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        analog_signal_loss_n[i] <= ALARM_N_RESET;
        digital_signal_loss_n[i] <= ALARM_N_RESET;
      end else begin
        // alarm test pulls both losses low
        analog_signal_loss_n[i] <= ~analog_signal_loss_n_reg[i] & alarm_test_n[i];
        digital_signal_loss_n[i] <= ~digital_signal_loss_n_reg[i] & alarm_test_n[i];
      end
    end
  end

  // shared pin: negative rail in dual rail, else polarity-adjusted violation
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) coding_violation_flag[i] <= alarm_polarity_select ? 1'b1 : 1'b0;
      else if (!alarm_test_n[i])
        coding_violation_flag[i] <= ~alarm_polarity_select;
      else if (dual_rail) coding_violation_flag[i] <= negbit_reg[i];
      else coding_violation_flag[i] <= bpv_reg[i] ^ alarm_polarity_select;
    end
  end

  // transmit alarms: drive monitor and transmit clock loss
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst) begin
        tx_drive_alarm_n[i] <= ALARM_N_RESET;
        tx_clock_loss_n[i] <= ALARM_N_RESET;
      end else begin
        // a primary fault or a long idle line pulls the monitor low
        tx_drive_alarm_n[i] <= alarm_test_n[i] & ~tx_primary_fault[i] &
                               (txzero_reg[i] < TX_IDLE_LIMIT);
        // recovered clock matters only while it feeds the line in remote loop
        tx_clock_loss_n[i] <= alarm_test_n[i] & ~(lost[i] |
                              (lost[4+i] & (loop_reg[i] == LOOP_REMOTE)) |
                              (lost[8+i] & ja_tx_enable) | lost[12+i]);
      end
    end
  end

  // reference loss: real loss, or test on every channel at once
  always_ff @(posedge ref_clk) begin
    if (rst) ref_clock_loss <= REF_LOSS_RESET;
    else ref_clock_loss <= lost[16] | (alarm_test_n == 4'h0);
  end

endmodule : line_alarm_loopback_control

// ==== test/line_alarm_sva.sv ====
// port assertions for the line alarm and loopback block
`timescale 1ns/1ps
module line_alarm_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dual_rail,
  input wire logic alarm_polarity_select,
  input wire logic [3:0] rx_below_low,
  input wire logic [3:0] rx_above_high,
  input wire logic [3:0] tx_bit_strobe,
  input wire logic [3:0] tx_primary_fault,
  input wire logic [3:0] alarm_test_n,
  input wire logic [3:0] full_local_loop_n,
  input wire logic [3:0] remote_loop_n,
  input wire logic [3:0] digital_local_loop_n,
  input wire logic [3:0] tx_alarm_indication,
  input wire logic [3:0] coding_violation_flag,
  input wire logic [3:0] analog_signal_loss_n,
  input wire logic [3:0] digital_signal_loss_n,
  input wire logic [3:0] tx_drive_alarm_n,
  input wire logic [3:0] tx_clock_loss_n,
  input wire logic ref_clock_loss,
  input wire logic [3:0] tx_line_pos,
  input wire logic [3:0] tx_line_neg,
  input wire logic [3:0] full_local_active,
  input wire logic [3:0] remote_active,
  input wire logic [3:0] digital_local_active
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_LOOP_ONE: assert property (((full_local_active & (remote_active | digital_local_active))
    | (remote_active & digital_local_active)) == 4'h0) else $error("two loops active");
  AST_REMOTE_SEL: assert property ((!remote_loop_n[0] && full_local_loop_n[0]
    && digital_local_loop_n[0])[*2] |=> remote_active[0]) else $error("remote loop missing");
  AST_MULTI_OFF: assert property ((!full_local_loop_n[1] && !digital_local_loop_n[1])[*2]
    |=> !full_local_active[1] && !digital_local_active[1]) else $error("loops not cancelled");
  AST_AIS_MARK: assert property (tx_alarm_indication[0][*2] ##0 tx_bit_strobe[0]
    |=> tx_line_pos[0] != tx_line_neg[0]) else $error("alarm signal bit not a mark");
  AST_TEST_FORCE: assert property ((!alarm_test_n[0])[*2] |-> !(digital_signal_loss_n[0]
    | analog_signal_loss_n[0] | tx_drive_alarm_n[0] | tx_clock_loss_n[0]))
    else $error("alarm test did not force alarms");
  AST_TEST_VIOL: assert property ((!alarm_test_n[0] && !dual_rail
    && $stable(alarm_polarity_select))[*2] |-> coding_violation_flag[0] != alarm_polarity_select)
    else $error("alarm test violation level wrong");
  AST_REF_TEST: assert property ((alarm_test_n == 4'h0)[*2] |-> ref_clock_loss)
    else $error("reference loss not forced");
  AST_ANALOG_SIGNAL_LOSS_N_SET: assert property (rx_below_low[0][*3] |-> !analog_signal_loss_n[0])
    else $error("analog loss not declared");
  AST_ANALOG_SIGNAL_LOSS_N_CLEAR: assert property ((rx_above_high[0] && !rx_below_low[0]
    && alarm_test_n[0])[*3] |-> analog_signal_loss_n[0]) else $error("analog loss not cleared");
  AST_ANALOG_SIGNAL_LOSS_N_HOLD: assert property ((!rx_below_low[0] && !rx_above_high[0]
    && alarm_test_n[0])[*4] |-> $stable(analog_signal_loss_n[0])) else $error("analog loss chatter");
  AST_DRIVE_FAULT: assert property (tx_primary_fault[0][*3] |-> !tx_drive_alarm_n[0])
    else $error("drive monitor missed fault");
endmodule : line_alarm_sva
bind line_alarm_loopback_control line_alarm_sva line_alarm_sva_i (.ref_clk, .rst, .dual_rail,
  .alarm_polarity_select, .rx_below_low, .rx_above_high, .tx_bit_strobe, .tx_primary_fault,
  .alarm_test_n, .full_local_loop_n, .remote_loop_n, .digital_local_loop_n, .tx_alarm_indication,
  .coding_violation_flag, .analog_signal_loss_n, .digital_signal_loss_n, .tx_drive_alarm_n,
  .tx_clock_loss_n, .ref_clock_loss, .tx_line_pos, .tx_line_neg, .full_local_active,
  .remote_active, .digital_local_active);

// ==== test/line_clock_model.sv ====
// terminal side clock sources: transmit, jitter, pulse-width and reference clocks
`timescale 1ns/1ps
module line_clock_model (
  input wire logic ref_clk,
  input wire logic [3:0] tx_stop,
  input wire logic ref_stop,
  output logic [3:0] tx_clock_in,
  output logic [3:0] ja_clock,
  output logic [3:0] pwc_clock,
  output logic reference_clock
);
  // all sources start low so the watcher sees a known level
  initial begin
    tx_clock_in = 4'h0;
    ja_clock = 4'h0;
    pwc_clock = 4'h0;
    reference_clock = 1'b0;
  end
  // a stopped source freezes at its level, as a dead oscillator would
  always @(posedge ref_clk) begin
    tx_clock_in <= tx_clock_in ^ ~tx_stop;
    ja_clock <= ja_clock ^ {4{~ref_stop}}; // derived from the reference
    pwc_clock <= ~pwc_clock;
    reference_clock <= reference_clock ^ ~ref_stop;
  end
endmodule : line_clock_model

// ==== test/tb.sv ====
// self-checking bench for the line alarm and loopback block
`timescale 1ns/1ps
module tb;
  import line_alarm_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, dual_rail = 1'b0, alarm_polarity_select = 1'b0;
  logic ja_tx_enable = 1'b0, ref_stop = 1'b0;
  logic [3:0] cept_mode = 4'h0, rx_bit_strobe = 4'h0, rx_line_positive = 4'h0;
  logic [3:0] rx_line_negative = 4'h0, rx_below_low = 4'h0, rx_above_high = 4'h0;
  logic [3:0] tx_bit_strobe = 4'h0, tx_data_pos = 4'h0, tx_data_neg = 4'h0;
  logic [3:0] tx_primary_fault = 4'h0, alarm_test_n = 4'hF, tx_alarm_indication = 4'h0;
  logic [3:0] full_local_loop_n = 4'hF, remote_loop_n = 4'hF, digital_local_loop_n = 4'hF;
  logic [3:0] tx_stop = 4'h0, p1;
  logic [3:0] tx_clock_in, ja_clock, pwc_clock, rx_data_out, rx_data_strobe;
  logic [3:0] coding_violation_flag, analog_signal_loss_n, digital_signal_loss_n;
  logic [3:0] tx_drive_alarm_n, tx_clock_loss_n, tx_line_pos, tx_line_neg;
  logic [3:0] full_local_active, remote_active, digital_local_active;
  logic reference_clock, ref_clock_loss;
  int err_count = 0, checks_done = 0, cycles = 0;
  logic [3:0] rx_q[$];  // receive bits noted by the driver, oldest first
  line_alarm_loopback_control line_alarm_loopback_control_i (.*);
  line_clock_model line_clock_model_i (.*);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  // compares one observed value with its expectation
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // one bit on all channels; rails go to their inverse once the strobe is gone
  task automatic send_bit(input logic [3:0] pos, input logic [3:0] neg);
    @(posedge ref_clk);
    rx_line_positive <= pos;
    rx_line_negative <= neg;
    rx_bit_strobe <= 4'hF;
    tx_bit_strobe <= 4'hF;
    rx_q.push_back(digital_local_loop_n == 4'h0 ? tx_data_pos : dual_rail ? pos : pos | neg);
    @(posedge ref_clk);
    rx_line_positive <= ~pos;
    rx_line_negative <= ~neg;
    rx_bit_strobe <= 4'h0;
    tx_bit_strobe <= 4'h0;
  endtask : send_bit
  task automatic bits(input int n, input logic [3:0] pos);
    repeat (n) send_bit(pos, 4'h0);
  endtask : bits
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // receive watcher: each delayed strobe retires the oldest noted bit
  always @(posedge ref_clk) begin
    if (!rst && rx_data_strobe[0] === 1'b1) begin
      if (rx_q.size() == 0) check(4'h1, 4'h0);
      else check(rx_data_out, rx_q.pop_front());
    end
  end
  // hang guard: the sequence needs about 2100 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hC0A3BFA0));
    tick(16);
    rst <= 1'b0;
    tick(2);
    #1 check(digital_signal_loss_n & analog_signal_loss_n & tx_drive_alarm_n, 4'hF);
    check(4'(ref_clock_loss), 4'h0);
    check(tx_clock_loss_n, 4'hF);
    repeat (40) send_bit(4'($urandom), 4'h0);
    send_bit(4'hF, 4'h0);
    send_bit(4'hF, 4'h0);
    tick(1);
    #1 check(coding_violation_flag, 4'hF);
    tick(1);
    alarm_polarity_select <= 1'b1;
    send_bit(4'h0, 4'hF);
    send_bit(4'h0, 4'hF);
    tick(1);
    #1 check(coding_violation_flag, 4'h0);
    tick(1);
    alarm_polarity_select <= 1'b0;
    dual_rail <= 1'b1;
    send_bit(4'h0, 4'h5);
    tick(1);
    #1 check(coding_violation_flag, 4'h5);
    send_bit(4'h0, 4'hA);
    tick(1);
    #1 check(coding_violation_flag, 4'hA);
    tick(1);
    dual_rail <= 1'b0;
    tx_data_pos <= 4'hF;
    bits(1, 4'hF);
    bits(99, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'hF);
    bits(1, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'h0);
    bits(12, 4'hF);
    bits(88, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'h0);
    bits(13, 4'hF);
    bits(87, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'hF);
    tick(1);
    cept_mode <= 4'hA;
    bits(1, 4'hF);
    bits(254, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'hA);
    bits(1, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n, 4'h0);
    bits(256, 4'hF);
    tick(1);
    #1 check(digital_signal_loss_n, 4'hF);
    tick(1);
    tx_primary_fault <= 4'h5;
    tick(3);
    #1 check(tx_drive_alarm_n, 4'hA);
    tick(1);
    tx_primary_fault <= 4'h0;
    tick(3);
    #1 check(tx_drive_alarm_n, 4'hF);
    tick(1);
    tx_data_pos <= 4'h0;
    bits(33, 4'h0);
    tick(1);
    #1 check(tx_drive_alarm_n, 4'h0);
    tick(1);
    rx_below_low <= 4'h3;
    tick(3);
    #1 check(analog_signal_loss_n, 4'hC);
    tick(1);
    rx_below_low <= 4'h0;
    tick(4);
    #1 check(analog_signal_loss_n, 4'hC);
    tick(1);
    rx_above_high <= 4'hF;
    tick(3);
    #1 check(analog_signal_loss_n, 4'hF);
    tick(1);
    rx_above_high <= 4'h0;
    alarm_test_n <= 4'h0;
    tx_data_pos <= 4'hF;
    send_bit(4'h0, 4'h0);
    tick(1);
    #1 check(digital_signal_loss_n | analog_signal_loss_n | tx_clock_loss_n, 4'h0);
    check(coding_violation_flag, 4'hF);
    check(4'(ref_clock_loss), 4'h1);
    check(tx_line_pos, 4'hF);
    tick(1);
    alarm_test_n <= 4'h7;
    tick(2);
    #1 check(4'(ref_clock_loss), 4'h0);
    check(tx_clock_loss_n, 4'h7);
    tick(1);
    alarm_test_n <= 4'hF;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      // several requests at once are part of this sweep on purpose
      {full_local_loop_n, remote_loop_n, digital_local_loop_n} <= {{4{i[2]}}, {4{i[1]}}, {4{i[0]}}};
      tick(3);
      #1 check(full_local_active, {4{i == 3}});
      check(remote_active, {4{i == 5}});
      check(digital_local_active, {4{i == 6}});
    end
    tick(1);
    remote_loop_n <= 4'h0;
    tick(2);
    send_bit(4'h6, 4'h0);
    tick(1);
    #1 check(tx_line_pos, 4'h6);
    tick(1);
    tx_alarm_indication <= 4'hF;
    send_bit(4'h0, 4'h0);
    tick(1);
    #1 check(tx_line_pos ^ tx_line_neg, 4'hF);
    p1 = tx_line_pos;
    send_bit(4'h0, 4'h0);
    tick(1);
    #1 check(tx_line_pos ^ tx_line_neg, 4'hF);
    check(tx_line_pos ^ p1, 4'hF);
    tick(1);
    tx_alarm_indication <= 4'h0;
    remote_loop_n <= 4'hF;
    tx_stop <= 4'h8;
    tick(100);
    #1 check(tx_clock_loss_n, 4'h7);
    tick(1);
    tx_stop <= 4'h0;
    ref_stop <= 1'b1;
    tick(100);
    #1 check(4'(ref_clock_loss), 4'h1);
    check(tx_clock_loss_n, 4'hF);
    tick(1);
    ja_tx_enable <= 1'b1;
    tick(2);
    #1 check(tx_clock_loss_n, 4'h0);
    tick(1);
    ref_stop <= 1'b0;
    tick(10);
    #1 check(4'(ref_clock_loss), 4'h0);
    check(tx_clock_loss_n, 4'hF);
    tick(1);
    digital_local_loop_n <= 4'h0;
    tx_data_pos <= 4'h5;
    tick(2);
    send_bit(4'hA, 4'h0);
    tick(2);
    check(4'(rx_q.size() == 0), 4'h1);
    stop_test();
  end
endmodule : tb
